// file: hdl/cscr_iout_calc.sv
// Converts sensed phase voltages into a calibrated current mantissa
`timescale 1ns/1ps
module cscr_iout_calc (
  input  wire logic [95:0] sense,    // Six 16b codes, LSB 1/64 mV
  input  wire logic [2:0]  slot,     // 0..5 phase, 6 total
  input  wire logic [10:0] gain_man, // Gain mantissa, LSB 1/64 mOhm
  input  wire logic [10:0] ofs_man,  // Offset mantissa, LSB 1/8 A
  output logic      [10:0] iout_man  // Current mantissa, LSB 1/8 A
);
  logic [18:0] total;
  logic [18:0] volt;
  logic [21:0] amp8;
  logic [10:0] amp_sat;
  logic [12:0] sum_s;

  always_comb begin
    total = '0;
    for (int i = 0; i < 6; i++) begin
      total = total + 19'(sense[i*16 +: 16]);
    end
  end

  assign volt = (slot == 3'd6) ? total : 19'(sense[32'(slot)*16 +: 16]);
  // Gain as scaling
  // Both codes share the 1/64 scale, so amperes are a plain quotient
  assign amp8 = (gain_man == 11'h000) ? 22'h3F_FFFF
              : ({volt, 3'b000} / {11'h000, gain_man});
  assign amp_sat = (amp8 > 22'h00_03FF) ? 11'h3FF : amp8[10:0];
  assign sum_s = {2'b00, amp_sat} + {{2{ofs_man[10]}}, ofs_man};
  // Only upward overflow is clamped; a negative offset sum passes through as its low 11 bits
  assign iout_man = (!sum_s[12] && sum_s[11:10] != 2'b00) ? 11'h3FF
                  : sum_s[10:0];
endmodule : cscr_iout_calc

// file: hdl/cscr_params.svh
// Offsets, field positions, reset values and codes of the calibration bank
`ifndef CSCR_PARAMS_SVH
`define CSCR_PARAMS_SVH
// Command codes
`define CSCR_CMD_PAGE       8'h00
`define CSCR_CMD_CLEAR      8'h03
`define CSCR_CMD_PHASE      8'h04
`define CSCR_CMD_STORE      8'h11
`define CSCR_CMD_GAIN       8'h38
`define CSCR_CMD_OFFSET     8'h39
`define CSCR_CMD_STAT_CML   8'h7E
`define CSCR_CMD_READ_IOUT  8'h8C
`define CSCR_CMD_LIMIT      8'hDA
`define CSCR_CMD_SHUNT      8'hDC
// Selector codes
`define CSCR_SEL_A          8'h00
`define CSCR_SEL_B          8'h01
`define CSCR_SEL_ALL        8'hFF
`define CSCR_PH_TOTAL       8'h80
`define CSCR_PH_LAST        8'h05
// Field positions
`define CSCR_SHUNT_SEL_HI   15
`define CSCR_SHUNT_SEL_LO   14
`define CSCR_SHUNT_ZERO     13
`define CSCR_BOOST_BIT      13
`define CSCR_CML_DATA_BIT   6
// Fixed exponents
`define CSCR_GAIN_EXP       5'h1A
`define CSCR_OFS_EXP        5'h1D
// Factory image
`define CSCR_GAIN_RST       11'h140
`define CSCR_OFS_RST        11'h000
`define CSCR_SHUNT_RST      16'hC000
`define CSCR_LIMIT_RST      16'h0000
// Acceptable calibration words
`define CSCR_GAIN_MIN       16'hD131
`define CSCR_GAIN_MAX       16'hD150
`define CSCR_OFS_POS_MAX    16'hE808
`define CSCR_OFS_NEG_MIN    16'hEFF9
`define CSCR_OFS_ZERO       16'hE800
`define CSCR_OFS_NEG_MAX    16'hEFFF
`define CSCR_OFS_TOT_MAX    16'hE81E
// Effective analog gain, LSB 0.05 mOhm
`define CSCR_AIN_0          7'd3
`define CSCR_AIN_1          7'd5
`define CSCR_AIN_2          7'd6
`define CSCR_AIN_3          7'd10
`define CSCR_AIN_4          7'd24
`define CSCR_AIN_5          7'd40
`define CSCR_AIN_6          7'd48
`define CSCR_AIN_7          7'd80
// Maximum temperature decode
`define CSCR_MAX_TEMPERATURE_CODE_BASE      8'd90
`define CSCR_MAX_TEMPERATURE_CODE_STEP      8'd5
`endif

// file: hdl/cscr_pkg.sv
// Types shared by the calibration bank
package cscr_pkg;
  // Decoded page selection
  typedef enum logic [1:0] {
    PG_A    = 2'b00,
    PG_B    = 2'b01,
    PG_BOTH = 2'b10,
    PG_BAD  = 2'b11
  } cscr_pg_t;
  typedef logic [10:0] cscr_man_t;
endpackage : cscr_pkg

// file: hdl/cscr_top.sv
// Current-sense calibration register bank served by word commands
// Operation
// - Shunt gain select is bits 15:14, page zero only, reset from NVM image.
// - Effective input gain decoded from boost bit and shunt select.
// - Max temperature code decodes to 90 C plus 5 C per step.
// - Current read returns the phase chosen by PHASE in channel PAGE.
// - PHASE 80h current read returns the sum of the channel's phases.
// - PHASE 80h aims gain and offset writes at the total measurement.
// - Stored gain mantissa scales sensed voltage into reported current.
// - Stored offset mantissa is added to current measurements.
// - Store-all command copies live calibration values into NVM image.
// - Gain calibration is code 38h, word reads and writes only.
// - Gain write targets channel A, B, or both with page FFh.
// - Gain write targets one phase, or all phases with PHASE FFh.
// - PHASE 80h gain write sets the channel's total-current scaling.
// - Gain exponent bits 15:11 read fixed 11010b, minus six.
// - Gain mantissa bits 10:0 writable, NVM reset, restricted values.
// - Unacceptable gain data is dropped, fault flag set, alert raised.
// - Boost control is bit 13 of limit register under page one.
`timescale 1ns/1ps
`include "cscr_params.svh"
module cscr_top (
  input  wire logic        mclk,           // 50 MHz clock
  input  wire logic        rst,            // Sync reset, active high
  input  wire logic        nvm_erase,      // Load factory image into NVM
  input  wire logic        cmd_valid,      // Decoded transaction strobe
  input  wire logic        cmd_write,      // 1 write, 0 read
  input  wire logic [7:0]  cmd_code,       // Command code
  input  wire logic [15:0] cmd_wdata,      // Word or byte in low bits
  input  wire logic [95:0] phase_sense_a,  // Channel A sense codes
  input  wire logic [95:0] phase_sense_b,  // Channel B sense codes
  input  wire logic [2:0]  max_temperature_code, // Temperature setting
  output logic             rsp_valid_r,    // Read answer pulse
  output logic [15:0]      rsp_data_r,     // Read answer word
  output logic             host_alert_output_n_r, // Alert, active low
  output logic             nvm_store_done_r, // Store finished pulse
  output logic [6:0]       input_gain_eff_r, // Effective gain, 0.05 mOhm
  output logic [7:0]       max_temp_degc_r // Decoded limit in C
);
  logic [10:0]       gain_r [0:13];
  logic [10:0]       ofs_r  [0:13];
  logic [10:0]       gain_nv[0:13];
  logic [10:0]       ofs_nv [0:13];
  logic [15:0]       lim_r  [0:1];
  logic [15:0]       lim_nv [0:1];
  logic [15:0]       shunt_r;
  logic [15:0]       shunt_nv;
  logic [7:0]        page_r;
  logic [7:0]        phase_r;
  logic              cml_fault_r;
  logic              cml_nxt;
  cscr_pkg::cscr_pg_t pg;
  logic              is_wr;
  logic              is_rd;
  logic              phase_ok;
  logic              loc_ok;
  logic              rd_ch;
  logic [2:0]        rd_slot;
  logic [3:0]        rd_idx;
  logic              word_ok;
  logic              gain_wr;
  logic              ofs_wr;
  logic              cal_bad;
  logic              shunt_wr;
  logic              lim_wr;
  logic              known;
  logic              set_fault;
  logic              clr_fault;
  logic              store;
  logic [10:0]       iout_man;
  logic [15:0]       rd_nxt;
  logic [10:0]       sel_gain;

  // Page decode, reused for gain, offset and limit writes; shunt writes compare the page directly
  function automatic cscr_pkg::cscr_pg_t pg_dec(input logic [7:0] p);
    if (p == `CSCR_SEL_A) begin
      return cscr_pkg::PG_A;
    end else if (p == `CSCR_SEL_B) begin
      return cscr_pkg::PG_B;
    end else if (p == `CSCR_SEL_ALL) begin
      return cscr_pkg::PG_BOTH;
    end
    return cscr_pkg::PG_BAD;
  endfunction : pg_dec

  // Slot of a phase code: 0..5 phases, 6 total
  function automatic logic [2:0] slot_of(input logic [7:0] ph);
    return (ph == `CSCR_PH_TOTAL) ? 3'd6
         : (ph <= `CSCR_PH_LAST) ? ph[2:0] : 3'd0;
  endfunction : slot_of

  // Does entry (c, s) take a write under the present selection
  function automatic logic hit(input logic c, input logic [2:0] s,
                               input cscr_pkg::cscr_pg_t p,
                               input logic [7:0] ph);
    logic ch_hit;
    logic sl_hit;
    ch_hit = (p == cscr_pkg::PG_BOTH) || (p == cscr_pkg::PG_B) == c;
    sl_hit = (ph == `CSCR_SEL_ALL) ? (s != 3'd6) : (s == slot_of(ph));
    return ch_hit && sl_hit;
  endfunction : hit

  function automatic logic [6:0] ain(input logic b, input logic [1:0] g);
    case ({b, g})
      3'd0:    return `CSCR_AIN_0;
      3'd1:    return `CSCR_AIN_1;
      3'd2:    return `CSCR_AIN_2;
      3'd3:    return `CSCR_AIN_3;
      3'd4:    return `CSCR_AIN_4;
      3'd5:    return `CSCR_AIN_5;
      3'd6:    return `CSCR_AIN_6;
      default: return `CSCR_AIN_7;
    endcase
  endfunction : ain

  // Transaction decode
  // Word commands
  assign is_wr    = cmd_valid && cmd_write;
  assign is_rd    = cmd_valid && !cmd_write;
  assign pg       = pg_dec(page_r);
  assign phase_ok = phase_r <= `CSCR_PH_LAST || phase_r == `CSCR_PH_TOTAL
                 || phase_r == `CSCR_SEL_ALL;
  assign loc_ok   = (pg != cscr_pkg::PG_BAD) && phase_ok;
  // Selection steers access
  // Broadcast selections read back channel A or phase 0
  assign rd_ch    = (page_r == `CSCR_SEL_B);
  assign rd_slot  = slot_of(phase_r);
  assign rd_idx   = {1'b0, rd_slot} + (rd_ch ? 4'd7 : 4'd0);
  assign sel_gain = gain_r[rd_idx];

  cscr_word_check u_check (
    .word     (cmd_wdata),
    .is_gain  (cmd_code == `CSCR_CMD_GAIN),
    .is_total (phase_r == `CSCR_PH_TOTAL),
    .ok       (word_ok)
  );

  assign gain_wr  = is_wr && cmd_code == `CSCR_CMD_GAIN && loc_ok
                 && word_ok;
  assign ofs_wr   = is_wr && cmd_code == `CSCR_CMD_OFFSET && loc_ok
                 && word_ok;
  assign cal_bad  = is_wr && (cmd_code == `CSCR_CMD_GAIN
                 || cmd_code == `CSCR_CMD_OFFSET) && !(loc_ok && word_ok);
  assign shunt_wr = is_wr && cmd_code == `CSCR_CMD_SHUNT
                 && page_r == `CSCR_SEL_A;
  assign lim_wr   = is_wr && cmd_code == `CSCR_CMD_LIMIT
                 && pg != cscr_pkg::PG_BAD;
  assign known    = cmd_code == `CSCR_CMD_PAGE
                 || cmd_code == `CSCR_CMD_CLEAR
                 || cmd_code == `CSCR_CMD_PHASE
                 || cmd_code == `CSCR_CMD_STORE
                 || cmd_code == `CSCR_CMD_GAIN
                 || cmd_code == `CSCR_CMD_OFFSET
                 || cmd_code == `CSCR_CMD_STAT_CML
                 || cmd_code == `CSCR_CMD_READ_IOUT
                 || cmd_code == `CSCR_CMD_LIMIT
                 || cmd_code == `CSCR_CMD_SHUNT;
  assign set_fault = cal_bad || (cmd_valid && !known)
                  || (is_wr && cmd_code == `CSCR_CMD_SHUNT && !shunt_wr)
                  || (is_wr && cmd_code == `CSCR_CMD_LIMIT && !lim_wr);
  assign clr_fault = is_wr && cmd_code == `CSCR_CMD_CLEAR;
  // Set wins so a fault in the clearing cycle is not lost
  assign cml_nxt   = set_fault || (cml_fault_r && !clr_fault);
  assign store     = is_wr && cmd_code == `CSCR_CMD_STORE;

  cscr_iout_calc u_calc (
    .sense    (rd_ch ? phase_sense_b : phase_sense_a),
    .slot     (rd_slot),
    .gain_man (sel_gain),
    .ofs_man  (ofs_r[rd_idx]),
    .iout_man (iout_man)
  );

  // Read mux
  // Stored word read
  always_comb begin
    case (cmd_code)
      `CSCR_CMD_PAGE:      rd_nxt = {8'h00, page_r};
      `CSCR_CMD_PHASE:     rd_nxt = {8'h00, phase_r};
      `CSCR_CMD_GAIN:      rd_nxt = {`CSCR_GAIN_EXP, sel_gain};
      `CSCR_CMD_OFFSET:    rd_nxt = {`CSCR_OFS_EXP, ofs_r[rd_idx]};
      `CSCR_CMD_READ_IOUT: rd_nxt = {`CSCR_OFS_EXP, iout_man};
      `CSCR_CMD_SHUNT:     rd_nxt = shunt_r;
      `CSCR_CMD_LIMIT:     rd_nxt = lim_r[rd_ch];
      `CSCR_CMD_STAT_CML:  rd_nxt = 16'(cml_fault_r) << `CSCR_CML_DATA_BIT;
      default:             rd_nxt = 16'h0000;
    endcase
  end

  // NVM image: survives rst, rewritten only by erase or store
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 14; i++) begin
      if (nvm_erase) begin
        gain_nv[i] <= `CSCR_GAIN_RST;
        ofs_nv[i]  <= `CSCR_OFS_RST;
      end else if (store) begin
        gain_nv[i] <= gain_r[i];
        ofs_nv[i]  <= ofs_r[i];
      end
    end
    if (nvm_erase) begin
      shunt_nv  <= `CSCR_SHUNT_RST;
      lim_nv[0] <= `CSCR_LIMIT_RST;
      lim_nv[1] <= `CSCR_LIMIT_RST;
    end else if (store) begin
      shunt_nv  <= shunt_r;
      lim_nv[0] <= lim_r[0];
      lim_nv[1] <= lim_r[1];
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < 14; i++) begin
      if (rst) begin
        gain_r[i] <= gain_nv[i];
        ofs_r[i]  <= ofs_nv[i];
      end else if (hit(i >= 7, 3'(i % 7), pg, phase_r)) begin
        if (gain_wr) begin
          gain_r[i] <= cmd_wdata[10:0];
        end
        if (ofs_wr) begin
          ofs_r[i] <= cmd_wdata[10:0];
        end
      end
    end
  end

  // Factory bits writable
  // Bit 13 of the shunt word is not stored and always reads zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      shunt_r <= shunt_nv;
    end else if (shunt_wr) begin
      shunt_r <= cmd_wdata & ~(16'h0001 << `CSCR_SHUNT_ZERO);
    end
  end

  always_ff @(posedge mclk) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) begin
        lim_r[c] <= lim_nv[c];
      end else if (lim_wr && (pg == cscr_pkg::PG_BOTH || rd_ch == c)) begin
        lim_r[c] <= cmd_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      page_r  <= 8'h00;
      phase_r <= 8'h00;
    end else if (is_wr && cmd_code == `CSCR_CMD_PAGE) begin
      page_r  <= cmd_wdata[7:0];
    end else if (is_wr && cmd_code == `CSCR_CMD_PHASE) begin
      phase_r <= cmd_wdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cml_fault_r           <= 1'b0;
      host_alert_output_n_r <= 1'b1;
    end else begin
      cml_fault_r           <= cml_nxt;
      host_alert_output_n_r <= !cml_nxt;
    end
  end

  // Answers and decoded outputs
  // Temperature decode
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_valid_r      <= 1'b0;
      rsp_data_r       <= 16'h0000;
      nvm_store_done_r <= 1'b0;
      input_gain_eff_r <= 7'd0;
      max_temp_degc_r  <= `CSCR_MAX_TEMPERATURE_CODE_BASE;
    end else begin
      rsp_valid_r      <= is_rd;
      rsp_data_r       <= is_rd ? rd_nxt : rsp_data_r;
      nvm_store_done_r <= store;
      input_gain_eff_r <= ain(lim_r[1][`CSCR_BOOST_BIT],
                              shunt_r[`CSCR_SHUNT_SEL_HI:
                                      `CSCR_SHUNT_SEL_LO]);
      max_temp_degc_r  <= `CSCR_MAX_TEMPERATURE_CODE_BASE
                        + `CSCR_MAX_TEMPERATURE_CODE_STEP * {5'd0, max_temperature_code};
    end
  end

  // Checks
  bad_gain_keep_a: assert property (@(posedge mclk) disable iff (rst)
    (cal_bad && cmd_code == `CSCR_CMD_GAIN) |=> $stable(sel_gain))
    else $error("bad gain word was stored");
  alert_raise_a: assert property (@(posedge mclk) disable iff (rst)
    cal_bad |=> (!host_alert_output_n_r && cml_fault_r) [*1] ##1
                (cml_fault_r || $past(clr_fault)))
    else $error("alert not raised on bad data");
  gain_read_a: assert property (@(posedge mclk) disable iff (rst)
    (is_rd && cmd_code == `CSCR_CMD_GAIN)
      |=> rsp_valid_r && rsp_data_r[10:0] == $past(sel_gain))
    else $error("gain read mismatch");
  gain_exp_a: assert property (@(posedge mclk) disable iff (rst)
    (is_rd && cmd_code == `CSCR_CMD_GAIN) |=> rsp_data_r[15:11] == 5'h1A)
    else $error("gain exponent wrong");
  gain_write_a: assert property (@(posedge mclk) disable iff (rst)
    (gain_wr && page_r == 8'h00 && phase_r == 8'h00)
      |=> gain_r[0] == $past(cmd_wdata[10:0]))
    else $error("gain write lost");
  both_chan_a: assert property (@(posedge mclk) disable iff (rst)
    (gain_wr && page_r == 8'hFF && phase_r == 8'hFF)
      |=> gain_r[1] == $past(cmd_wdata[10:0])
       && gain_r[8] == $past(cmd_wdata[10:0]))
    else $error("broadcast page write missed a channel");
  all_phase_a: assert property (@(posedge mclk) disable iff (rst)
    (gain_wr && page_r != 8'h01 && phase_r == 8'hFF)
      |=> gain_r[0] == $past(cmd_wdata[10:0])
       && gain_r[5] == $past(cmd_wdata[10:0]) && $stable(gain_r[6]))
    else $error("broadcast phase write wrong");
  total_slot_a: assert property (@(posedge mclk) disable iff (rst)
    (gain_wr && page_r == 8'h00 && phase_r == 8'h80)
      |=> gain_r[6] == $past(cmd_wdata[10:0]) && $stable(gain_r[0]))
    else $error("total gain slot not written");
  shunt_page_a: assert property (@(posedge mclk) disable iff (rst)
    (is_wr && cmd_code == `CSCR_CMD_SHUNT && page_r != 8'h00)
      |=> $stable(shunt_r) && cml_fault_r)
    else $error("shunt written off page zero");
  temp_dec_a: assert property (@(posedge mclk) disable iff (rst)
    (max_temperature_code == 3'd7) [*2] |-> max_temp_degc_r == 8'd125)
    else $error("temperature decode wrong");
  boost_gain_a: assert property (@(posedge mclk) disable iff (rst)
    (lim_r[1][13] && shunt_r[15:14] == 2'b00) |=> input_gain_eff_r == 7'd24)
    else $error("boost gain decode wrong");
  page_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !(is_wr && cmd_code == `CSCR_CMD_PAGE) |=> $stable(page_r))
    else $error("page changed without write");
  store_copy_a: assert property (@(posedge mclk) disable iff (rst)
    (store && !nvm_erase) |=> gain_nv[6] == $past(gain_r[6]))
    else $error("store did not copy");
  cov_total_rd: cover property (@(posedge mclk) disable iff (rst)
    is_rd && cmd_code == `CSCR_CMD_READ_IOUT && phase_r == 8'h80);
  cov_bad_gain: cover property (@(posedge mclk) disable iff (rst)
    cal_bad && cmd_code == `CSCR_CMD_GAIN);
  cov_store: cover property (@(posedge mclk) disable iff (rst) store);
endmodule : cscr_top

// file: hdl/cscr_word_check.sv
// Acceptable-value check for calibration words
`timescale 1ns/1ps
`include "cscr_params.svh"
module cscr_word_check (
  input  wire logic [15:0] word,     // Written word
  input  wire logic        is_gain,  // Gain word, else offset word
  input  wire logic        is_total, // Offset aimed at total slot
  output logic             ok        // Word may be stored
);
  logic gain_ok;
  logic ofs_ind_ok;
  logic ofs_tot_ok;

  // Gain set is one contiguous span; offset sets differ per target
  assign gain_ok    = word >= `CSCR_GAIN_MIN && word <= `CSCR_GAIN_MAX;
  assign ofs_ind_ok = (word >= `CSCR_OFS_ZERO && word <= `CSCR_OFS_POS_MAX)
                   || (word >= `CSCR_OFS_NEG_MIN && word <= `CSCR_OFS_NEG_MAX);
  assign ofs_tot_ok = word >= `CSCR_OFS_ZERO && word <= `CSCR_OFS_TOT_MAX
                   && !word[0];
  assign ok = is_gain ? gain_ok : (is_total ? ofs_tot_ok : ofs_ind_ok);
endmodule : cscr_word_check

// file: tb/cscr_stage_model.sv
// Behavioural power stages feeding per-phase sense codes to the bank
`timescale 1ns/1ps
module cscr_stage_model (
  input  wire logic [47:0] amps_a,  // Channel A phase currents, 1 A steps
  input  wire logic [47:0] amps_b,  // Channel B phase currents, 1 A steps
  output logic      [95:0] sense_a, // Channel A sense codes
  output logic      [95:0] sense_b  // Channel B sense codes
);
  // Five mV per ampere
  // 5 mV/A at 1/64 mV per code is 320 codes per ampere; no noise is
  // modelled, so small calibration shifts show up exactly
  for (genvar i = 0; i < 6; i++) begin : g_ph
    assign sense_a[16*i+:16] = {8'h00, amps_a[8*i+:8]} * 16'h0140;
    assign sense_b[16*i+:16] = {8'h00, amps_b[8*i+:8]} * 16'h0140;
  end
endmodule : cscr_stage_model

// file: tb/cscr_top_tb.sv
// Self-checking bench for the calibration bank command port
`timescale 1ns/1ps
`include "cscr_params.svh"
module cscr_top_tb;
  logic        mclk, rst, nvm_erase, cmd_valid, cmd_write;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rd_word;
  logic [95:0] sense_a, sense_b;
  logic [47:0] amps_a, amps_b;
  logic [2:0]  tcode;
  logic        rsp_valid, alert_n, store_done;
  logic [15:0] rsp_data;
  logic [6:0]  gain_eff;
  logic [7:0]  temp_degc;
  int          err_total, n_compared;
  logic [6:0]  ain_tab [8] = '{7'd3, 7'd5, 7'd6, 7'd10,
                                7'd24, 7'd40, 7'd48, 7'd80};

  cscr_stage_model i_stage (.amps_a(amps_a), .amps_b(amps_b),
                            .sense_a(sense_a), .sense_b(sense_b));
  cscr_top i_dut (
    .mclk(mclk), .rst(rst), .nvm_erase(nvm_erase), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .phase_sense_a(sense_a), .phase_sense_b(sense_b),
    .max_temperature_code(tcode), .rsp_valid_r(rsp_valid),
    .rsp_data_r(rsp_data), .host_alert_output_n_r(alert_n),
    .nvm_store_done_r(store_done), .input_gain_eff_r(gain_eff),
    .max_temp_degc_r(temp_degc));

  // Free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // One-cycle strobe, raised and dropped on falling edges
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge mclk);
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {2'b11, code, data};
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : wr

  // Answer stands one cycle after the taking edge
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    @(negedge mclk);
    {cmd_valid, cmd_write, cmd_code} = {2'b10, code};
    @(negedge mclk);
    // The answer pulse stands only in the cycle after the taking edge
    chk("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
    data = rsp_data;
    cmd_valid = 1'b0;
  endtask : rd

  task automatic sel(input logic [7:0] page, input logic [7:0] phase);
    wr(`CSCR_CMD_PAGE, {8'h00, page});
    wr(`CSCR_CMD_PHASE, {8'h00, phase});
  endtask : sel

  // Reset is synchronous, so it is held across several edges
  task automatic do_reset(input logic erase);
    @(negedge mclk);
    {rst, nvm_erase} = {1'b1, erase};
    repeat (5) @(negedge mclk);
    {rst, nvm_erase} = 2'b00;
  endtask : do_reset

  // Expected current word: floor scaling, clamp, then offset
  function automatic logic [15:0] exp_cur(int amps, int gain, int ofs);
    int v;
    v = amps * 2560 / gain;
    if (v > 1023) v = 1023;
    v = v + ofs;
    return {5'h1D, v[10:0]};
  endfunction : exp_cur

  // Watchdog sized well above the whole sequence
  initial begin
    #(20 * 5000);
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    {rst, nvm_erase, cmd_valid, cmd_write} = 4'b1100;
    {cmd_code, cmd_wdata, tcode} = '0;
    amps_a = {8'd6, 8'd5, 8'd4, 8'd3, 8'd2, 8'd1};
    amps_b = {8'd12, 8'd10, 8'd8, 8'd6, 8'd4, 8'd2};
    repeat (5) @(negedge mclk);
    {rst, nvm_erase} = 2'b00;
    rd(`CSCR_CMD_GAIN, rd_word);
    chk("gain reset", rd_word, 16'hD140);
    rd(`CSCR_CMD_SHUNT, rd_word);
    chk("shunt reset", rd_word, 16'hC000);
    for (int k = 0; k < 8; k++) begin
      tcode = k[2:0];
      repeat (2) @(negedge mclk);
      chk("max temp", {8'h00, temp_degc}, 16'(90 + 5 * k));
    end
    sel(`CSCR_SEL_A, 8'h00);
    rd(`CSCR_CMD_READ_IOUT, rd_word);
    chk("iout A ph0", rd_word, exp_cur(1, 320, 0));
    sel(`CSCR_SEL_B, 8'h01);
    rd(`CSCR_CMD_READ_IOUT, rd_word);
    chk("iout B ph1", rd_word, exp_cur(4, 320, 0));
    wr(`CSCR_CMD_PHASE, {8'h00, `CSCR_PH_TOTAL});
    rd(`CSCR_CMD_READ_IOUT, rd_word);
    chk("iout B total", rd_word, exp_cur(42, 320, 0));
    for (int k = 0; k < 8; k++) begin
      sel(`CSCR_SEL_B, 8'h00);
      wr(`CSCR_CMD_LIMIT, {2'b00, k[2], 13'h0000});
      sel(`CSCR_SEL_A, 8'h00);
      wr(`CSCR_CMD_SHUNT, {k[1:0], 14'h0000});
      repeat (2) @(negedge mclk);
      chk("gain eff", {9'h000, gain_eff}, {9'h000, ain_tab[k]});
    end
    wr(`CSCR_CMD_SHUNT, 16'hC123);
    rd(`CSCR_CMD_SHUNT, rd_word);
    chk("shunt word", rd_word, 16'hC123);
    wr(`CSCR_CMD_PAGE, {8'h00, `CSCR_SEL_B});
    wr(`CSCR_CMD_SHUNT, 16'h4000);
    @(negedge mclk);
    chk("alert shunt", {15'h0, alert_n}, 16'h0000);
    wr(`CSCR_CMD_CLEAR, 16'h0000);
    @(negedge mclk);
    chk("alert clear", {15'h0, alert_n}, 16'h0001);
    sel(`CSCR_SEL_ALL, `CSCR_SEL_ALL);
    wr(`CSCR_CMD_GAIN, 16'hD131);
    sel(`CSCR_SEL_B, 8'h03);
    rd(`CSCR_CMD_GAIN, rd_word);
    chk("gain B ph3", rd_word, 16'hD131);
    rd(`CSCR_CMD_READ_IOUT, rd_word);
    chk("iout scaled", rd_word, exp_cur(8, 305, 0));
    wr(`CSCR_CMD_PHASE, {8'h00, `CSCR_PH_TOTAL});
    rd(`CSCR_CMD_GAIN, rd_word);
    chk("gain B total", rd_word, 16'hD140);
    sel(`CSCR_SEL_A, `CSCR_PH_TOTAL);
    wr(`CSCR_CMD_GAIN, 16'hD150);
    rd(`CSCR_CMD_GAIN, rd_word);
    chk("gain A total", rd_word, 16'hD150);
    rd(`CSCR_CMD_READ_IOUT, rd_word);
    chk("iout A total", rd_word, exp_cur(21, 336, 0));
    wr(`CSCR_CMD_GAIN, 16'hD100);
    @(negedge mclk);
    chk("alert bad", {15'h0, alert_n}, 16'h0000);
    rd(`CSCR_CMD_STAT_CML, rd_word);
    chk("cml flag", {15'h0, rd_word[6]}, 16'h0001);
    rd(`CSCR_CMD_GAIN, rd_word);
    chk("gain kept", rd_word, 16'hD150);
    wr(`CSCR_CMD_CLEAR, 16'h0000);
    wr(`CSCR_CMD_PHASE, 16'h0000);
    wr(`CSCR_CMD_GAIN, 16'hD13D);
    wr(`CSCR_CMD_OFFSET, 16'hE808);
    rd(`CSCR_CMD_READ_IOUT, rd_word);
    chk("iout offset", rd_word, exp_cur(1, 317, 8));
    wr(`CSCR_CMD_STORE, 16'h0000);
    chk("store done", {15'h0, store_done}, 16'h0001);
    do_reset(1'b0);
    rd(`CSCR_CMD_GAIN, rd_word);
    chk("gain stored", rd_word, 16'hD13D);
    test_done();
  end
endmodule : cscr_top_tb
